// ===== bridge_term_engine.sv
// Master-side termination engine of the bridge with Wishbone registers
`timescale 1ns/1ps
module bridge_term_engine #(
    parameter int unsigned RETRY_LIMIT = 32'h0100_0000,
    parameter int unsigned PF_BYTES    = 64
)(
    input  logic              core_clk,
    input  logic              sys_rst,
    input  logic              cyc_i,
    input  logic              stb_i,
    input  logic              we_i,
    input  logic [4:0]        adr_i,
    input  logic [3:0]        sel_i,
    input  logic [31:0]       dat_i,
    output logic [31:0]       dat_o,
    output logic              ack_o,
    input  term_pkg::pciIn_s  pciIn,
    output term_pkg::pciOut_s pciOut,
    input  logic              dwRetryIn,
    output term_pkg::resp_s   resp,
    output logic              xferDone,
    output logic              primary_system_error_out,
    output logic              primary_system_error_oe
);
    import term_pkg::*;

    // Refuse limits the counter and boundary logic cannot serve
    if (RETRY_LIMIT < 2 || RETRY_LIMIT > 32'h0100_0000) $error("bad RETRY_LIMIT");
    if (PF_BYTES < 8 || (PF_BYTES & (PF_BYTES - 1)) != 0) $error("bad PF_BYTES");

    localparam logic [23:0] LIM_M1  = 24'(RETRY_LIMIT - 1);
    localparam logic [31:0] PF_MASK = 32'(PF_BYTES - 1);
    localparam logic [31:0] PF_LAST = 32'(PF_BYTES - 4);

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ADDR  = 6'h02,
        ST_WAIT  = 6'h04,
        ST_DATA  = 6'h08,
        ST_DROPF = 6'h10,
        ST_FIN   = 6'h20
    } state_e;

    state_e      state;       // Master sequencer
    outc_e       outc;        // How the attempt ended
    logic [31:0] ctrl;        // Control register
    logic [6:0]  stat;        // Sticky status
    logic [31:0] curAddr;     // Address of next word to deliver
    logic [15:0] cmdReg;      // Command, kind, flags, count
    logic [7:0]  rem;         // Data phases still owed
    logic [23:0] attempts;    // Retries seen by this transaction
    logic [2:0]  waitCnt;     // Clocks since FRAME
    logic [7:0]  latCnt;      // Master latency timer
    logic        seenDevsel;  // DEVSEL observed this attempt
    logic        xfered;      // Data moved this attempt
    logic        abortPend;   // Next initiator retry gets target abort
    logic        serrPulse;   // Error pin drive
    logic [3:0]  s1, s2, s3, pinF;

    // Byte-lane merge for register writes
    function automatic logic [31:0] mergeSel(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        return o;
    endfunction

    // Target termination decode
    function automatic outc_e termDecode(input logic dv, input logic tr, input logic sp,
                                         input logic xf, input logic seen);
        if (sp && dv && tr)
            return OC_DISC;
        else if (sp && dv)
            return xf ? OC_DISC : OC_RETRY;
        else if (sp && !tr && seen)
            return OC_TA;
        return OC_NONE;
    endfunction

    // Three-flop pin sync; the filtered level follows when stages two and three agree
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s1 <= 4'hf;
            s2 <= 4'hf;
            s3 <= 4'hf;
        end
        else
        begin
            s1 <= pciIn;
            s2 <= s1;
            s3 <= s2;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gFilt
            // Per-pin agreement filter
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                    pinF[g] <= 1'b1;
                else if (s2[g] == s3[g])
                    pinF[g] <= s3[g];
            end
        end
    endgenerate

    wire       devsel = ~pinF[3];
    wire       trdy   = ~pinF[2];
    wire       stop   = ~pinF[1];
    wire       gnt    = ~pinF[0];
    kind_e     kind;
    wire       multi  = cmdReg[CMD_MULTI];
    wire       tgtSec = cmdReg[CMD_SEC];
    assign kind = kind_e'(cmdReg[CMD_KIND +: 2]);

    // Ending conditions of a burst
    wire latCut = (latCnt == 8'h00) && !gnt && (cmdReg[3:0] != PCMD_MWI);
    wire pfEdge = (kind == K_PR) && ((curAddr & PF_MASK) == PF_LAST);
    wire last   = (rem == 8'h01) || pfEdge || latCut;
    wire frameOn = (state == ST_ADDR && gnt) || ((state == ST_WAIT || state == ST_DATA) && !last);
    wire irdyOn  = state == ST_WAIT || state == ST_DATA || state == ST_DROPF;
    outc_e tdec;
    assign tdec = termDecode(devsel, trdy, stop, xfered, seenDevsel);

    // Wishbone decode
    wire wbHit   = cyc_i && stb_i;
    wire wbWrite = wbHit && we_i && ack_o;
    wire launch  = wbWrite && adr_i == REG_CMD && state == ST_IDLE;

    // Completion decisions taken in the final cycle
    logic       finReissue;
    logic       incAtt;
    logic       setPend;
    logic       serrFire;
    logic       respFire;
    rsp_e       respCode;
    logic [6:0] setSts;
    wire [1:0]  tSide = {1'b0, tgtSec};
    wire [1:0]  iSide = {1'b0, ~tgtSec};
    wire        limHit = attempts == LIM_M1;
    wire        isDelayed = kind != K_PW;

    // Outcome handling per transaction kind
    always_comb
    begin
        finReissue = 1'b0;
        incAtt     = 1'b0;
        setPend    = 1'b0;
        serrFire   = 1'b0;
        respFire   = 1'b0;
        respCode   = RSP_DONE;
        setSts     = 7'h00;
        if (state == ST_FIN)
        begin
            unique case (outc)
                OC_NORM, OC_DISC, OC_LAT:
                begin
                    if (!isDelayed)
                        finReissue = rem != 8'h00;
                    else
                    begin
                        respFire = 1'b1;
                        respCode = (multi && kind == K_DW) ? RSP_DISC : RSP_DONE;
                    end
                end
                OC_MA:
                begin
                    setSts[STS_RMA + tSide] = 1'b1;
                    if (isDelayed)
                    begin
                        respFire = 1'b1;
                        respCode = ctrl[CTL_MAMODE] ? RSP_TABORT
                                 : (kind == K_DW ? RSP_DONE : RSP_ONES);
                        setSts[STS_STA + iSide] = ctrl[CTL_MAMODE];
                    end
                    else
                        serrFire = ctrl[CTL_MAMODE] && ctrl[CTL_SERREN]
                                   && !ctrl[CTL_DISPWMA];
                end
                OC_RETRY:
                begin
                    incAtt = 1'b1;
                    if (limHit && isDelayed)
                    begin
                        setPend  = 1'b1;
                        serrFire = ctrl[CTL_SERREN] && !ctrl[CTL_DISDLIM];
                    end
                    else if (limHit)
                        serrFire = ctrl[CTL_SERREN] && !ctrl[CTL_DISPLIM];
                    else
                    begin
                        finReissue = 1'b1;
                        respFire   = isDelayed;
                        respCode   = RSP_RETRY;
                    end
                end
                OC_TA:
                begin
                    setSts[STS_RTA + tSide] = 1'b1;
                    if (isDelayed)
                    begin
                        respFire = 1'b1;
                        respCode = RSP_TABORT;
                        setSts[STS_STA + iSide] = 1'b1;
                    end
                    else
                        serrFire = ctrl[CTL_SERREN];
                end
                default:
                begin
                    finReissue = 1'b0;
                end
            endcase
            setSts[STS_SSE] = serrFire;
        end
    end

    // Master sequencer
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            outc  <= OC_NONE;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (launch)
                        state <= ST_ADDR;
                ST_ADDR:
                    if (gnt)
                        state <= ST_WAIT;
                ST_WAIT:
                    if (devsel)
                        state <= ST_DATA;
                    else if (waitCnt == DEVSEL_CLKS)
                    begin
                        outc  <= OC_MA;
                        state <= frameOn ? ST_DROPF : ST_FIN;
                    end
                ST_DATA:
                    if (tdec != OC_NONE)
                    begin
                        outc  <= tdec;
                        state <= frameOn ? ST_DROPF : ST_FIN;
                    end
                    else if (trdy && last)
                    begin
                        outc  <= (latCut && rem != 8'h01 && !pfEdge) ? OC_LAT : OC_NORM;
                        state <= ST_FIN;
                    end
                ST_DROPF:
                    state <= ST_FIN;
                ST_FIN:
                    state <= finReissue ? ST_ADDR : ST_IDLE;
            endcase
        end
    end

    // Per-attempt counters and flags
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            waitCnt    <= 3'h0;
            latCnt     <= 8'h00;
            seenDevsel <= 1'b0;
            xfered     <= 1'b0;
        end
        else if (state == ST_ADDR)
        begin
            waitCnt    <= 3'h1;
            latCnt     <= ctrl[CTL_LAT +: 8];
            seenDevsel <= 1'b0;
            xfered     <= 1'b0;
        end
        else
        begin
            if (state == ST_WAIT && waitCnt != DEVSEL_CLKS)
                waitCnt <= waitCnt + 3'h1;
            if (latCnt != 8'h00)
                latCnt <= latCnt - 8'h01;
            if (devsel)
                seenDevsel <= 1'b1;
            if (state == ST_DATA && trdy)
                xfered <= 1'b1;
        end
    end

    // Transaction descriptor and delivery progress
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            curAddr  <= 32'h0000_0000;
            cmdReg   <= 16'h0000;
            rem      <= 8'h00;
            attempts <= 24'h00_0000;
            xferDone <= 1'b0;
        end
        else
        begin
            xferDone <= state == ST_DATA && trdy;
            if (wbWrite && adr_i == REG_ADDR && state == ST_IDLE)
                curAddr <= mergeSel(curAddr, dat_i, sel_i);
            else if (state == ST_DATA && trdy)
            begin
                curAddr <= curAddr + 32'h4;
                rem     <= rem - 8'h01;
            end
            if (launch)
            begin
                cmdReg   <= 16'(mergeSel({16'h0000, cmdReg}, dat_i, sel_i));
                rem      <= (dat_i[CMD_KIND +: 2] == K_DW || dat_i[CMD_KIND +: 2] == K_NPR)
                            ? 8'h01 : dat_i[CMD_CNT +: 8];
                attempts <= 24'h00_0000;
            end
            else if (incAtt)
                attempts <= attempts + 24'h1;
            else if (finReissue && outc != OC_RETRY && cmdReg[3:0] == PCMD_MWI)
                cmdReg[3:0] <= PCMD_MW;
        end
    end

    // Answers towards the initiator and pending abort
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            resp      <= '{valid: 1'b0, code: RSP_DONE};
            abortPend <= 1'b0;
        end
        else if (respFire)
            resp <= '{valid: 1'b1, code: respCode};
        else if (dwRetryIn && abortPend)
        begin
            resp      <= '{valid: 1'b1, code: RSP_TABORT};
            abortPend <= 1'b0;
        end
        else
            resp.valid <= 1'b0;
        if (!sys_rst && setPend)
            abortPend <= 1'b1;
    end

    // Error pin pulse
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            serrPulse <= 1'b0;
        else
            serrPulse <= serrFire;
    end
    assign primary_system_error_out = 1'b0;
    assign primary_system_error_oe  = serrPulse;

    // Control and status registers; a set in the clearing cycle wins
    wire abortAns = dwRetryIn && abortPend && !respFire;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl <= CTRL_RST;
            stat <= STAT_RST;
        end
        else
        begin
            if (wbWrite && adr_i == REG_CTRL)
                ctrl <= mergeSel(ctrl, dat_i, sel_i) & CTRL_MASK;
            stat <= (stat & ~((wbWrite && adr_i == REG_STAT && sel_i[0]) ? dat_i[6:0] : 7'h00))
                    | setSts | (abortAns ? 7'(1 << (STS_STA + iSide)) : 7'h00);
        end
    end

    // Wishbone slave: ack one cycle after the strobe, read data with it
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= wbHit && !ack_o;
            unique case (adr_i)
                REG_CTRL: dat_o <= ctrl;
                REG_STAT: dat_o <= {25'h0, stat};
                REG_ADDR: dat_o <= curAddr;
                REG_CMD:  dat_o <= {attempts, 6'h0, abortPend, state != ST_IDLE};
                default:  dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Target-bus pins
    assign pciOut = '{frameN: ~frameOn, frameOe: state != ST_IDLE, irdyN: ~irdyOn,
                      irdyOe: state != ST_IDLE, ad: curAddr, adOe: state == ST_ADDR,
                      cbe: state == ST_ADDR ? cmdReg[3:0] : 4'h0};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    masterAbort_a: assert property (
        state == ST_WAIT && !devsel && waitCnt == DEVSEL_CLKS |=> outc == OC_MA)
        else $error("no master abort after five clocks");
    dropOrder_a: assert property (
        state == ST_DROPF |-> !frameOn && irdyOn ##1 !irdyOn)
        else $error("abort drop order wrong");
    lastFrame_a: assert property (
        state == ST_DATA && last && trdy |-> pciOut.frameN && !pciOut.irdyN ##1 pciOut.irdyN)
        else $error("frame held in last phase");
    retryDecode_a: assert property (
        state == ST_DATA && stop && devsel && !trdy && !xfered |=> outc == OC_RETRY)
        else $error("retry not decoded");
    abortDecode_a: assert property (
        state == ST_DATA && stop && !devsel && !trdy |=> outc == OC_TA)
        else $error("target abort not decoded");
    pwSerr_a: assert property (
        state == ST_FIN && outc == OC_MA && kind == K_PW |=>
        serrPulse == (ctrl[CTL_MAMODE] && ctrl[CTL_SERREN] && !ctrl[CTL_DISPWMA]))
        else $error("posted abort error gating wrong");
    dwRetry_a: assert property (
        state == ST_FIN && outc == OC_RETRY && kind == K_DW && !limHit
        |=> resp.valid && resp.code == RSP_RETRY ##1 state == ST_WAIT || state == ST_ADDR)
        else $error("delayed retry not answered");
    mwiSplit_a: assert property (
        state == ST_FIN && outc == OC_DISC && kind == K_PW && rem != 8'h00
        && cmdReg[3:0] == PCMD_MWI |=> cmdReg[3:0] == PCMD_MW)
        else $error("remainder kept invalidate command");
    prefNoRepeat_a: assert property (
        state == ST_FIN && outc == OC_LAT && kind == K_PR |=> state == ST_IDLE)
        else $error("prefetch read repeated");
    limitPend_a: assert property (
        state == ST_FIN && outc == OC_RETRY && isDelayed && limHit |=> abortPend && state == ST_IDLE)
        else $error("retry limit not handled");

    masterAbortSeen_c: cover property (state == ST_WAIT ##1 outc == OC_MA);
    pwDisc_c: cover property (state == ST_FIN && outc == OC_DISC && kind == K_PW && finReissue);
    dwDone_c: cover property (resp.valid && resp.code == RSP_DISC);
    latCut_c: cover property (state == ST_FIN && outc == OC_LAT);
endmodule

// ===== bridge_transaction_termination_tb_top.sv
// Self-checking bench for the bridge termination engine
`timescale 1ns/1ps
module bridge_transaction_termination_tb_top;
    import term_pkg::*;
    typedef struct packed {
        logic [7:0]  ctl;
        logic [15:0] cmd;
        logic [2:0]  md;
        logic [6:0]  st;
        logic [2:0]  rs;
        logic [3:0]  nx;
        logic        se;
    } row_s;
    logic        core_clk, sys_rst, cyc, stb, we, dwRetryIn, slow, ack, xferDone, serrOe, serrOut;
    logic [4:0]  adr;
    logic [3:0]  sel, lastCbe;
    logic [31:0] dat, datO, q, a, lastAd;
    logic [2:0]  mode, lastRsp;
    pciIn_s      pciIn;
    pciOut_s     pciOut;
    resp_s       resp;
    int          errors, checked, bx, bs, n, k, i, cnt, seed, nA;
    int          nX = 0;
    int          nSerr = 0;
    row_s        rows [17];
    bridge_term_engine #(.RETRY_LIMIT(4)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(datO), .ack_o(ack), .pciIn(pciIn), .pciOut(pciOut), .dwRetryIn(dwRetryIn),
        .resp(resp), .xferDone(xferDone), .primary_system_error_out(serrOut),
        .primary_system_error_oe(serrOe));
    pci_target_model TGT (.pciOut(pciOut), .core_clk(core_clk), .sys_rst(sys_rst),
        .mode(mode), .slow(slow), .pciIn(pciIn));
    // Clock generator
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Log answers, error pulses, data phases and address phases
    always @(posedge core_clk)
    begin
        if (resp.valid)
            lastRsp <= resp.code;
        if (serrOe)
            nSerr <= nSerr + 1;
        if (xferDone)
            nX <= nX + 1;
        if (pciOut.adOe)
            {lastAd, lastCbe, nA} <= {pciOut.ad, pciOut.cbe, nX};
    end
    task end_of_test;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task hang;
        errors++;
        end_of_test;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic Wishbone cycle, bounded wait for ack
    task wb(input logic w, input logic [4:0] ad, input logic [31:0] d);
        n = 0;
        @(posedge core_clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, ad, d};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (!ack && n < 40);
        q = datO;
        {cyc, stb} <= 2'b00;
        if (!ack)
            hang;
    endtask
    // Program control, launch one transfer, poll until idle
    task run(input logic [7:0] ctl, input logic [15:0] cmd, input logic [2:0] md);
        mode <= md;
        wb(1'b1, REG_CTRL, {16'h0, (ctl[7] ? 8'h02 : 8'h20), ctl});
        wb(1'b1, REG_STAT, 32'h7f);
        wb(1'b1, REG_ADDR, a);
        bx = nX;
        bs = nSerr;
        lastRsp = 3'd7;
        wb(1'b1, REG_CMD, {16'h0, cmd});
        for (k = 0; k < 100; k++)
        begin
            wb(1'b0, REG_CMD, '0);
            if (!q[0])
                break;
        end
        if (q[0])
            hang;
        repeat (4) @(posedge core_clk);
    endtask
    initial
    begin
        {cyc, stb, we, adr, dat, dwRetryIn, slow, mode} = '0;
        sel = 4'hf;
        seed = 54;
        errors = 0;
        checked = 0;
        rows = '{'{8'h03, 16'h0117, 3'd4, 7'h01, 3'd7, 4'd0, 1'b1},
                 '{8'h07, 16'h0117, 3'd4, 7'h01, 3'd7, 4'd0, 1'b0},
                 '{8'h02, 16'h0117, 3'd4, 7'h01, 3'd7, 4'd0, 1'b0},
                 '{8'h03, 16'h0197, 3'd4, 7'h02, 3'd7, 4'd0, 1'b1},
                 '{8'h03, 16'h0047, 3'd0, 7'h00, 3'd1, 4'd1, 1'b0},
                 '{8'h03, 16'h0007, 3'd0, 7'h00, 3'd0, 4'd1, 1'b0},
                 '{8'h03, 16'h0047, 3'd2, 7'h00, 3'd1, 4'd1, 1'b0},
                 '{8'h03, 16'h0007, 3'd3, 7'h24, 3'd3, 4'd0, 1'b0},
                 '{8'h03, 16'h0117, 3'd3, 7'h44, 3'd7, 4'd0, 1'b1},
                 '{8'h03, 16'h0026, 3'd4, 7'h01, 3'd3, 4'd0, 1'b0},
                 '{8'h02, 16'h0026, 3'd4, 7'h01, 3'd4, 4'd0, 1'b0},
                 '{8'h03, 16'h031f, 3'd2, 7'h00, 3'd7, 4'd3, 1'b0},
                 '{8'h03, 16'h0117, 3'd1, 7'h00, 3'd7, 4'd0, 1'b1},
                 '{8'h03, 16'h1036, 3'd0, 7'h00, 3'd0, 4'd2, 1'b0},
                 '{8'h83, 16'h0c17, 3'd5, 7'h00, 3'd7, 4'd12, 1'b0},
                 '{8'h83, 16'h1036, 3'd5, 7'h00, 3'd0, 4'd6, 1'b0},
                 '{8'h03, 16'h0007, 3'd1, 7'h00, 3'd2, 4'd0, 1'b1}};
        sys_rst = 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values, unmapped location reads zero
        wb(1'b0, REG_CTRL, '0);
        chk(q, CTRL_RST);
        wb(1'b0, REG_STAT, '0);
        chk(q, {25'h0, STAT_RST});
        wb(1'b1, 5'h10, 32'hffff_ffff);
        wb(1'b0, 5'h10, '0);
        chk(q, 32'h0);
        // Table of target terminations
        for (i = 0; i < 17; i++)
        begin
            a = $random(seed) & 32'hffff_fffc;
            if (rows[i].cmd[5:4] == 2'h3)
                a[5:2] = rows[i].md == 3'd5 ? 4'h0 : 4'he;
            run(rows[i].ctl, rows[i].cmd, rows[i].md);
            wb(1'b0, REG_STAT, '0);
            chk(q[6:0] & (7'h0f | rows[i].st), rows[i].st);
            chk(nX - bx, rows[i].nx);
            chk(nSerr != bs, rows[i].se);
            if (rows[i].rs != 3'd7)
                chk(lastRsp, rows[i].rs);
            if (rows[i].md == 3'd1 && rows[i].cmd[5:4] == 2'h1)
                chk(lastAd, a);
            if (rows[i].md == 3'd2 && rows[i].cmd[5:4] == 2'h1)
            begin
                chk(lastAd, a + 32'h8);
                chk(lastCbe, PCMD_MW);
            end
            if (rows[i].md == 3'd5)
            begin
                chk(lastAd, a + 32'((nA - bx) * 4));
                chk(nA != bx, rows[i].cmd[5:4] == 2'h1);
            end
        end
        // Dropped delayed write answers the next attempt with abort
        wb(1'b0, REG_CMD, '0);
        chk(q[1], 1'b1);
        dwRetryIn <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (!resp.valid && n < 20);
        dwRetryIn <= 1'b0;
        chk({resp.valid, resp.code}, {1'b1, RSP_TABORT});
        wb(1'b0, REG_STAT, '0);
        chk(q[5], 1'b1);
        chk(serrOut, 1'b0);
        // Random posted bursts, target sometimes slow
        for (i = 0; i < 4; i++)
        begin
            cnt = 1 + ($random(seed) & 3);
            slow <= cnt[0];
            a = $random(seed) & 32'hffff_fffc;
            run(8'h03, {cnt[7:0], 8'h17}, 3'd0);
            chk(nX - bx, cnt);
        end
        end_of_test;
    end
endmodule

// ===== pci_target_model.sv
// Behavioural PCI target that answers the bridge on its target bus
`timescale 1ns/1ps
module pci_target_model (
    input  wire term_pkg::pciOut_s pciOut,
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [2:0]        mode,
    input  wire logic              slow,
    output term_pkg::pciIn_s       pciIn
);
    import term_pkg::*;
    logic       sel;  // Claimed by this target
    logic [3:0] age;  // Cycles since the claim
    logic       ta;   // Abort phase reached
    // Claim on FRAME; let go once FRAME and IRDY are both high
    always_ff @(posedge core_clk)
        if (sys_rst)
            sel <= 1'b0;
        else if (!sel)
            sel <= pciOut.frameOe && !pciOut.frameN;
        else if (pciOut.frameN && pciOut.irdyN)
            sel <= 1'b0;
    // Age of the claim, saturating
    always_ff @(posedge core_clk)
        if (!sel)
            age <= 4'h0;
        else if (age != 4'hf)
            age <= age + 4'h1;
    // Abort only after DEVSEL has been shown for several cycles
    assign ta = (mode == 3'd3) && (age > 4'd3);
    // Mode 0 normal, 1 retry, 2 disconnect, 3 abort, 4 silent, 5 normal, grant withdrawn
    // Idle DEVSEL, TRDY and STOP float high; GNT stays low
    assign pciIn.devselN = !(sel && mode != 3'd4 && !ta);
    assign pciIn.trdyN   = !(sel && (mode == 3'd2 || ((mode == 3'd0 || mode == 3'd5) &&
                             age >= {2'b0, slow, 1'b0})));
    assign pciIn.stopN   = !(sel && (mode == 3'd1 || mode == 3'd2 || ta));
    // Bus parked on the bridge; mode 5 takes the grant away mid-burst
    assign pciIn.gntN    = sel && mode == 3'd5 && age > 4'd5;
endmodule

// ===== term_pkg.sv
// Constants and carrier types for the bridge transaction termination engine
// Summary of operation
// - Master abort when no DEVSEL in five clocks
// - Abort drops FRAME, then IRDY next cycle
// - FRAME off at last phase, IRDY after
// - Decode target retry and both disconnects
// - Target abort only after DEVSEL was seen
// - End after one word, boundary, or drain
// - End on latency cut or target stop
// - Latency cut posted write resumes next word
// - Latency cut prefetch read is not repeated
// - Delayed abort answers ones (read), done (write) or target abort
// - Posted write abort discards, flags status side
// - Posted abort error needs mode, enable, undisabled
// - Delayed write retried until done or aborted
// - Disconnect answer only for multiphase requests
// - Delayed write retry answers retry, keeps trying
// - Delayed target abort passed back, both flagged
// - Retry limit: error, drop, abort next attempt
// - Posted write retried, disconnect resends remainder
// - Posted target abort flags status and error
// - Retry keeps address, disconnect uses current
// - Split invalidate write resent as memory write
// - Posted retry limit discards data, error
package term_pkg;
    // Register word offsets (byte addresses)
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h04;
    localparam logic [4:0] REG_ADDR = 5'h08;
    localparam logic [4:0] REG_CMD  = 5'h0c;
    // Control field positions
    localparam int CTL_MAMODE  = 0;
    localparam int CTL_SERREN  = 1;
    localparam int CTL_DISPWMA = 2;
    localparam int CTL_DISDLIM = 3;
    localparam int CTL_DISPLIM = 4;
    localparam int CTL_LAT     = 8;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_ff1f;
    // Status field positions
    localparam int STS_RMA = 0;
    localparam int STS_RTA = 2;
    localparam int STS_STA = 4;
    localparam int STS_SSE = 6;
    localparam logic [6:0] STAT_RST = 7'h00;
    // Command register fields
    localparam int CMD_KIND  = 4;
    localparam int CMD_MULTI = 6;
    localparam int CMD_SEC   = 7;
    localparam int CMD_CNT   = 8;
    // Bus commands touched by the engine
    localparam logic [3:0] PCMD_MW  = 4'h7;
    localparam logic [3:0] PCMD_MWI = 4'hf;
    // Clocks allowed for DEVSEL after FRAME
    localparam logic [2:0] DEVSEL_CLKS = 3'h5;
    localparam logic [31:0] ONES = 32'hffff_ffff;
    typedef enum logic [1:0] {K_DW = 2'h0, K_PW = 2'h1, K_NPR = 2'h2, K_PR = 2'h3} kind_e;
    typedef enum logic [2:0] {OC_NONE, OC_NORM, OC_MA, OC_RETRY, OC_DISC, OC_TA, OC_LAT} outc_e;
    typedef enum logic [2:0] {RSP_DONE, RSP_DISC, RSP_RETRY, RSP_TABORT, RSP_ONES} rsp_e;
    // Target-bus inputs, active low
    typedef struct packed {logic devselN; logic trdyN; logic stopN; logic gntN;} pciIn_s;
    // Target-bus master outputs
    typedef struct packed {
        logic        frameN;
        logic        frameOe;
        logic        irdyN;
        logic        irdyOe;
        logic [31:0] ad;
        logic        adOe;
        logic [3:0]  cbe;
    } pciOut_s;
    // Answer towards the initiating bus
    typedef struct packed {logic valid; rsp_e code;} resp_s;
endpackage
